// ===== tcx_timer_ctrl.sv
// Timer 0/1/2 counters, external request flags and their control registers
`timescale 1ns/1ns
`include "tcx_consts.svh"
// Notes on behaviour
// - Timer 1 overflow sets flag, except in timer 0 split mode where timer 0 high byte overflow sets it; vectoring clears it
// - Timer 1 counts only while run bit set
// - Timer 0 overflow sets flag; vectoring clears it
// - Timer 0 counts only while run bit set, except its split-mode high byte (timer 1 run bit)
// - Request 1 set by fall or low level
// - Vector clears edge requests; level requests follow pin
// - Request 1 select: set edge, clear level
// - Request 0 set by fall or low level
// - Request 0 select: set edge, clear level
// - Timer 2 overflow flag, never in baud use
// - Trigger fall with enable sets external flag
// - Receive baud from timer 2 or timer 1
// - Transmit baud from timer 2 or timer 1
// - Trigger enable gates capture/reload unless baud use
// - Timer 2 counts only while run bit set
// - Timer 2 source: count pin or core clock
// - Capture select: capture, else autoreload
// - Baud use forces autoreload, ignores capture select
// - Timer 0/1 byte registers, reset zero
// - Timer 2 byte registers, reset zero
// - Gate bit makes timer 1 need high pin
// - Mode 01 cascades bytes into 16 bits
// - Timer 2 rollover reloads from reload pair; capture mode rolls to zero
// - Capture copies count into reload pair
module tcx_timer_ctrl (
    input  wire logic       I_CLK,           // Core clock, 125 MHz
    input  wire logic       I_RST_N,         // Sync reset, active low
    input  wire logic [7:0] I_SFR_ADDR,      // Byte register address
    input  wire logic       I_SFR_WR,        // Byte write strobe
    input  wire logic [7:0] I_SFR_WDATA,     // Byte write data
    input  wire logic       I_SFR_RD,        // Byte read strobe
    output logic      [7:0] O_SFR_RDATA,     // Read data, next cycle
    input  wire logic       I_BIT_WR,        // Single-bit write strobe
    input  wire logic [7:0] I_BIT_ADDR,      // Bit address
    input  wire logic       I_BIT_VAL,       // Bit value
    input  wire logic       I_VEC_TMR0,      // Core vectors to timer 0
    input  wire logic       I_VEC_TMR1,      // Core vectors to timer 1
    input  wire logic       I_VEC_EXT0,      // Core vectors to request 0
    input  wire logic       I_VEC_EXT1,      // Core vectors to request 1
    input  wire logic       I_EXT0_PIN,      // External request 0 pin
    input  wire logic       I_EXT1_PIN,      // External request 1 pin
    input  wire logic       I_TMR0_CNT_PIN,  // Timer 0 count pin
    input  wire logic       I_TMR1_CNT_PIN,  // Timer 1 count pin
    input  wire logic       I_TMR2_CNT_PIN,  // Timer 2 count pin
    input  wire logic       I_TMR2_TRIG_PIN, // Timer 2 trigger pin
    output logic            O_TMR0_OVF_FLAG, // Timer 0 overflow flag
    output logic            O_TMR1_OVF_FLAG, // Timer 1 overflow flag
    output logic            O_EXT0_REQ,      // Request 0 flag
    output logic            O_EXT1_REQ,      // Request 1 flag
    output logic            O_TMR2_IRQ,      // Timer 2 overflow or external flag
    output logic            O_RX_BAUD_TICK,  // Receive baud tick pulse
    output logic            O_TX_BAUD_TICK   // Transmit baud tick pulse
);
    import tcx_pkg::*;

    tcx_state_t s_r;
    tcx_state_t s_nxt;

    logic [`TCX_NPINS-1:0] pin_lvl;
    logic [`TCX_NPINS-1:0] pin_fall;

    logic        t0_split;
    logic        t0_ev;
    logic        t1_ev;
    logic        t2_ev;
    logic [16:0] r0;
    logic [16:0] r1;
    logic [8:0]  h0;
    logic        ovf_h0;
    logic        set_ovf0;
    logic        set_ovf1;
    logic        baud2;
    logic        trig2;
    logic        ovf2;
    logic        set_ovf2;
    logic [15:0] cnt2;
    logic [15:0] rld2;
    logic [15:0] cnt2_nxt;
    logic        wr_c01;
    logic        wr_c2;

    tcx_pin_sync u_sync (
        .i_clk   (I_CLK),
        .i_rst_n (I_RST_N),
        .i_pins  ({I_TMR2_TRIG_PIN, I_TMR2_CNT_PIN, I_TMR1_CNT_PIN,
                   I_TMR0_CNT_PIN, I_EXT1_PIN, I_EXT0_PIN}),
        .o_level (pin_lvl),
        .o_fall  (pin_fall)
    );

    // One step of a timer 0/1 pair in the given mode: {overflow, high, low}
    function automatic logic [16:0] tmr_step(input logic [1:0] md, input logic [7:0] lo,
                                             input logic [7:0] hi, input logic ev);
        logic [13:0] c13;
        logic [16:0] c16;
        logic [8:0]  c8;
        logic [16:0] r;
        c13 = {1'b0, hi, lo[4:0]} + 14'h0001;
        c16 = {1'b0, hi, lo} + 17'h00001;
        c8  = {1'b0, lo} + 9'h001;
        r   = {1'b0, hi, lo};
        if (ev)
        begin
            case (md)
                `TCX_MODE_13BIT:   r = {c13[13], c13[12:5], lo[7:5], c13[4:0]};
                `TCX_MODE_16BIT:   r = c16;
                `TCX_MODE_RELOAD8: r = c8[8] ? {1'b1, hi, hi} : {1'b0, hi, c8[7:0]};
                default:           r = {c8[8], hi, c8[7:0]};
            endcase
        end
        return r;
    endfunction

    // Single-bit update for bit-addressed writes
    function automatic logic [7:0] put_bit(input logic [7:0] v, input logic [2:0] idx,
                                           input logic b);
        logic [7:0] r;
        r      = v;
        r[idx] = b;
        return r;
    endfunction

    always_comb
    begin
        s_nxt = s_r;

        // Timer 0 and timer 1 counting
        t0_split = s_r.mode[1:0] == `TCX_MODE_SPLIT;
        t0_ev    = s_r.ctl01[`TCX_B_RUN0]
                   && (!s_r.mode[`TCX_B_GATE0] || pin_lvl[`TCX_P_EXT0])
                   && (s_r.mode[`TCX_B_SRC0] ? pin_fall[`TCX_P_CNT0] : 1'b1);
        t1_ev    = s_r.ctl01[`TCX_B_RUN1]
                   && (!s_r.mode[`TCX_B_TIMER1_PIN_GATING] || pin_lvl[`TCX_P_EXT1])
                   && (s_r.mode[`TCX_B_SRC1] ? pin_fall[`TCX_P_CNT1] : 1'b1)
                   && (s_r.mode[5:4] != `TCX_MODE_SPLIT);
        r0       = tmr_step(s_r.mode[1:0], s_r.lo0, s_r.hi0, t0_ev);
        r1       = tmr_step(s_r.mode[5:4], s_r.lo1, s_r.hi1, t1_ev);
        // Split mode: high byte of timer 0 runs on the timer 1 run bit
        h0       = {1'b0, s_r.hi0} + 9'h001;
        ovf_h0   = t0_split && s_r.ctl01[`TCX_B_RUN1] && h0[8];
        s_nxt.lo0 = r0[7:0];
        s_nxt.hi0 = t0_split ? (s_r.ctl01[`TCX_B_RUN1] ? h0[7:0] : s_r.hi0) : r0[15:8];
        s_nxt.lo1 = r1[7:0];
        s_nxt.hi1 = r1[15:8];
        set_ovf0  = r0[16];
        set_ovf1  = t0_split ? ovf_h0 : r1[16];

        // Timer 2 counting, reload and capture
        baud2    = s_r.ctl2[`TCX_B_RXBAUD] || s_r.ctl2[`TCX_B_TXBAUD];
        cnt2     = {s_r.hi2, s_r.lo2};
        rld2     = {s_r.rld_hi, s_r.rld_lo};
        t2_ev    = s_r.ctl2[`TCX_B_RUN2]
                   && (s_r.ctl2[`TCX_B_SRC2] ? pin_fall[`TCX_P_CNT2] : 1'b1);
        trig2    = s_r.ctl2[`TCX_B_TRIGEN2] && pin_fall[`TCX_P_TRIG2];
        ovf2     = t2_ev && (cnt2 == `TCX_CNT_MAX);
        cnt2_nxt = cnt2;
        if (ovf2)
            cnt2_nxt = (baud2 || !s_r.ctl2[`TCX_B_TIMER2_CAPTURE_SELECT]) ? rld2 : 16'h0000;
        else if (t2_ev)
            cnt2_nxt = cnt2 + 16'h0001;
        if (trig2 && !baud2 && !s_r.ctl2[`TCX_B_TIMER2_CAPTURE_SELECT])
            cnt2_nxt = rld2;
        if (trig2 && !baud2 && s_r.ctl2[`TCX_B_TIMER2_CAPTURE_SELECT])
            {s_nxt.rld_hi, s_nxt.rld_lo} = cnt2;
        s_nxt.hi2 = cnt2_nxt[15:8];
        s_nxt.lo2 = cnt2_nxt[7:0];
        set_ovf2  = ovf2 && !baud2;

        // Baud ticks from the selected timer
        s_nxt.rx_tick = s_r.ctl2[`TCX_B_RXBAUD] ? ovf2 : r1[16];
        s_nxt.tx_tick = s_r.ctl2[`TCX_B_TXBAUD] ? ovf2 : r1[16];

        // Vector acknowledge clears
        if (I_VEC_TMR0)
            s_nxt.ctl01[`TCX_B_OVF0] = 1'b0;
        if (I_VEC_TMR1)
            s_nxt.ctl01[`TCX_B_OVF1] = 1'b0;
        if (I_VEC_EXT0 && s_r.ctl01[`TCX_B_XEDGE0])
            s_nxt.ctl01[`TCX_B_XREQ0] = 1'b0;
        if (I_VEC_EXT1 && s_r.ctl01[`TCX_B_XEDGE1])
            s_nxt.ctl01[`TCX_B_XREQ1] = 1'b0;

        // Byte writes override the count step of this cycle
        wr_c01 = (I_SFR_WR && I_SFR_ADDR == `TCX_A_TMR01_CTRL)
                 || (I_BIT_WR && {I_BIT_ADDR[7:3], 3'h0} == `TCX_A_TMR01_CTRL);
        wr_c2  = (I_SFR_WR && I_SFR_ADDR == `TCX_A_TMR2_CTRL)
                 || (I_BIT_WR && {I_BIT_ADDR[7:3], 3'h0} == `TCX_A_TMR2_CTRL);
        if (I_SFR_WR)
        begin
            case (I_SFR_ADDR)
                `TCX_A_TMR01_CTRL:  s_nxt.ctl01  = I_SFR_WDATA;
                `TCX_A_TMR_MODE:    s_nxt.mode   = I_SFR_WDATA;
                `TCX_A_TMR0_LOW:    s_nxt.lo0    = I_SFR_WDATA;
                `TCX_A_TMR1_LOW:    s_nxt.lo1    = I_SFR_WDATA;
                `TCX_A_TMR0_HIGH:   s_nxt.hi0    = I_SFR_WDATA;
                `TCX_A_TMR1_HIGH:   s_nxt.hi1    = I_SFR_WDATA;
                `TCX_A_TMR2_CTRL:   s_nxt.ctl2   = I_SFR_WDATA;
                `TCX_A_TMR2_RLD_LO: s_nxt.rld_lo = I_SFR_WDATA;
                `TCX_A_TMR2_RLD_HI: s_nxt.rld_hi = I_SFR_WDATA;
                `TCX_A_TMR2_LOW:    s_nxt.lo2    = I_SFR_WDATA;
                `TCX_A_TMR2_HIGH:   s_nxt.hi2    = I_SFR_WDATA;
                default:            s_nxt.rdata  = s_nxt.rdata;
            endcase
        end
        if (I_BIT_WR && {I_BIT_ADDR[7:3], 3'h0} == `TCX_A_TMR01_CTRL)
            s_nxt.ctl01 = put_bit(s_nxt.ctl01, I_BIT_ADDR[2:0], I_BIT_VAL);
        if (I_BIT_WR && {I_BIT_ADDR[7:3], 3'h0} == `TCX_A_TMR2_CTRL)
            s_nxt.ctl2 = put_bit(s_nxt.ctl2, I_BIT_ADDR[2:0], I_BIT_VAL);

        // Hardware sets win over clears in the same cycle
        if (set_ovf0)
            s_nxt.ctl01[`TCX_B_OVF0] = 1'b1;
        if (set_ovf1)
            s_nxt.ctl01[`TCX_B_OVF1] = 1'b1;
        if (s_r.ctl01[`TCX_B_XEDGE0])
        begin
            if (pin_fall[`TCX_P_EXT0])
                s_nxt.ctl01[`TCX_B_XREQ0] = 1'b1;
        end
        else
            s_nxt.ctl01[`TCX_B_XREQ0] = !pin_lvl[`TCX_P_EXT0];
        if (s_r.ctl01[`TCX_B_XEDGE1])
        begin
            if (pin_fall[`TCX_P_EXT1])
                s_nxt.ctl01[`TCX_B_XREQ1] = 1'b1;
        end
        else
            s_nxt.ctl01[`TCX_B_XREQ1] = !pin_lvl[`TCX_P_EXT1];
        if (set_ovf2)
            s_nxt.ctl2[`TCX_B_OVF2] = 1'b1;
        if (trig2)
            s_nxt.ctl2[`TCX_B_EXTF2] = 1'b1;

        // Read data registered on the read strobe
        if (I_SFR_RD)
        begin
            case (I_SFR_ADDR)
                `TCX_A_TMR01_CTRL:  s_nxt.rdata = s_r.ctl01;
                `TCX_A_TMR_MODE:    s_nxt.rdata = s_r.mode;
                `TCX_A_TMR0_LOW:    s_nxt.rdata = s_r.lo0;
                `TCX_A_TMR1_LOW:    s_nxt.rdata = s_r.lo1;
                `TCX_A_TMR0_HIGH:   s_nxt.rdata = s_r.hi0;
                `TCX_A_TMR1_HIGH:   s_nxt.rdata = s_r.hi1;
                `TCX_A_TMR2_CTRL:   s_nxt.rdata = s_r.ctl2;
                `TCX_A_TMR2_RLD_LO: s_nxt.rdata = s_r.rld_lo;
                `TCX_A_TMR2_RLD_HI: s_nxt.rdata = s_r.rld_hi;
                `TCX_A_TMR2_LOW:    s_nxt.rdata = s_r.lo2;
                `TCX_A_TMR2_HIGH:   s_nxt.rdata = s_r.hi2;
                default:            s_nxt.rdata = `TCX_RST_BYTE;
            endcase
        end
    end

    always_ff @(posedge I_CLK)
    begin
        if (!I_RST_N)
            s_r <= '0;
        else
            s_r <= s_nxt;
    end

    assign O_SFR_RDATA     = s_r.rdata;
    assign O_TMR0_OVF_FLAG = s_r.ctl01[`TCX_B_OVF0];
    assign O_TMR1_OVF_FLAG = s_r.ctl01[`TCX_B_OVF1];
    assign O_EXT0_REQ      = s_r.ctl01[`TCX_B_XREQ0];
    assign O_EXT1_REQ      = s_r.ctl01[`TCX_B_XREQ1];
    assign O_TMR2_IRQ      = s_r.ctl2[`TCX_B_OVF2] || s_r.ctl2[`TCX_B_EXTF2];
    assign O_RX_BAUD_TICK  = s_r.rx_tick;
    assign O_TX_BAUD_TICK  = s_r.tx_tick;

    a_ovf1_set: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
        set_ovf1 |=> O_TMR1_OVF_FLAG)
        else $error("timer 1 overflow flag not set");

    a_ovf1_vector: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
        (I_VEC_TMR1 && !set_ovf1 && !wr_c01) |=> !O_TMR1_OVF_FLAG)
        else $error("timer 1 flag not cleared on vector");

    a_run1_hold: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
        (!s_r.ctl01[`TCX_B_RUN1] && !I_SFR_WR) |=> ($stable(s_r.lo1) && $stable(s_r.hi1)))
        else $error("timer 1 moved while stopped");

    a_ovf0_mode1: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
        (t0_ev && s_r.mode[1:0] == `TCX_MODE_16BIT && {s_r.hi0, s_r.lo0} == 16'hFFFF)
        |=> (O_TMR0_OVF_FLAG && s_r.lo0 == 8'h00 && s_r.hi0 == 8'h00) or $past(I_SFR_WR))
        else $error("timer 0 16-bit rollover wrong");

    a_run0_count: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
        (s_r.ctl01[`TCX_B_RUN0] && !s_r.mode[`TCX_B_GATE0] && !s_r.mode[`TCX_B_SRC0]
         && s_r.mode[1:0] == `TCX_MODE_16BIT && !I_SFR_WR)
        |=> {s_r.hi0, s_r.lo0} == $past({s_r.hi0, s_r.lo0}) + 16'h0001)
        else $error("timer 0 did not step");

    a_ext1_edge: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
        (s_r.ctl01[`TCX_B_XEDGE1] && pin_fall[`TCX_P_EXT1]) |=> O_EXT1_REQ)
        else $error("request 1 edge lost");

    a_ext0_level: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
        !s_r.ctl01[`TCX_B_XEDGE0] |=> (O_EXT0_REQ == !$past(pin_lvl[`TCX_P_EXT0])))
        else $error("request 0 does not follow level");

    a_ovf2_baud: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
        (baud2 && !s_r.ctl2[`TCX_B_OVF2] && !wr_c2) |=> !s_r.ctl2[`TCX_B_OVF2])
        else $error("timer 2 flag set in baud use");

    a_trig_flag: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
        trig2 |=> s_r.ctl2[`TCX_B_EXTF2])
        else $error("external flag not set");

    a_cap_copy: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
        (trig2 && !baud2 && s_r.ctl2[`TCX_B_TIMER2_CAPTURE_SELECT] && !I_SFR_WR)
        |=> {s_r.rld_hi, s_r.rld_lo} == $past(cnt2))
        else $error("capture value wrong");

    a_baud_reload: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
        (ovf2 && baud2 && !I_SFR_WR) |=> (cnt2 == $past(rld2) && O_RX_BAUD_TICK == $past(s_r.ctl2[5])))
        else $error("baud reload or tick wrong");

    a_run2_hold: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
        (!s_r.ctl2[`TCX_B_RUN2] && !trig2 && !I_SFR_WR) |=> $stable(cnt2))
        else $error("timer 2 moved while stopped");

    a_src2_pin: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
        (s_r.ctl2[`TCX_B_RUN2] && s_r.ctl2[`TCX_B_SRC2] && !pin_fall[`TCX_P_CNT2] && !trig2 && !I_SFR_WR)
        |=> $stable(cnt2))
        else $error("timer 2 stepped without count pin fall");

    a_timer1_pin_gating_hold: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
        (s_r.mode[`TCX_B_TIMER1_PIN_GATING] && !pin_lvl[`TCX_P_EXT1] && !I_SFR_WR)
        |=> ($stable(s_r.lo1) && $stable(s_r.hi1)))
        else $error("timer 1 moved while gated off");

    a_tx_tick_src: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
        !s_r.ctl2[`TCX_B_TXBAUD] |=> (O_TX_BAUD_TICK == $past(r1[16])))
        else $error("transmit tick not from timer 1");

endmodule

// ===== tcx_consts.svh
// Register offsets, field positions, reset values and pin indices of the timer block
`ifndef TCX_CONSTS_SVH
`define TCX_CONSTS_SVH

// Byte offsets on the special-function port
`define TCX_A_TMR01_CTRL   8'h88
`define TCX_A_TMR_MODE     8'h89
`define TCX_A_TMR0_LOW     8'h8A
`define TCX_A_TMR1_LOW     8'h8B
`define TCX_A_TMR0_HIGH    8'h8C
`define TCX_A_TMR1_HIGH    8'h8D
`define TCX_A_TMR2_CTRL    8'hC8
`define TCX_A_TMR2_RLD_LO  8'hCA
`define TCX_A_TMR2_RLD_HI  8'hCB
`define TCX_A_TMR2_LOW     8'hCC
`define TCX_A_TMR2_HIGH    8'hCD

// Timer 0/1 and external request control bits
`define TCX_B_OVF1         7
`define TCX_B_RUN1         6
`define TCX_B_OVF0         5
`define TCX_B_RUN0         4
`define TCX_B_XREQ1        3
`define TCX_B_XEDGE1       2
`define TCX_B_XREQ0        1
`define TCX_B_XEDGE0       0

// Timer 2 control bits
`define TCX_B_OVF2         7
`define TCX_B_EXTF2        6
`define TCX_B_RXBAUD       5
`define TCX_B_TXBAUD       4
`define TCX_B_TRIGEN2      3
`define TCX_B_RUN2         2
`define TCX_B_SRC2         1
`define TCX_B_TIMER2_CAPTURE_SELECT         0

// Mode register fields
`define TCX_B_TIMER1_PIN_GATING        7
`define TCX_B_SRC1         6
`define TCX_B_GATE0        3
`define TCX_B_SRC0         2
`define TCX_MODE_13BIT     2'h0
`define TCX_MODE_16BIT     2'h1
`define TCX_MODE_RELOAD8   2'h2
`define TCX_MODE_SPLIT     2'h3

`define TCX_RST_BYTE       8'h00
`define TCX_CNT_MAX        16'hFFFF

// Pin indices in the synchroniser
`define TCX_NPINS          6
`define TCX_P_EXT0         0
`define TCX_P_EXT1         1
`define TCX_P_CNT0         2
`define TCX_P_CNT1         3
`define TCX_P_CNT2         4
`define TCX_P_TRIG2        5

`endif

// ===== tcx_pkg.sv
// State types of the timer block
package tcx_pkg;
`include "tcx_consts.svh"

    typedef struct packed {
        logic [`TCX_NPINS-1:0] s1;
        logic [`TCX_NPINS-1:0] s2;
        logic [`TCX_NPINS-1:0] s3;
    } tcx_sync_t;

    typedef struct packed {
        logic [7:0] ctl01;
        logic [7:0] mode;
        logic [7:0] ctl2;
        logic [7:0] lo0;
        logic [7:0] hi0;
        logic [7:0] lo1;
        logic [7:0] hi1;
        logic [7:0] lo2;
        logic [7:0] hi2;
        logic [7:0] rld_lo;
        logic [7:0] rld_hi;
        logic [7:0] rdata;
        logic       rx_tick;
        logic       tx_tick;
    } tcx_state_t;

endpackage

// ===== tcx_pin_sync.sv
// Two-stage pin synchroniser with falling-edge pulses
`timescale 1ns/1ns
`include "tcx_consts.svh"
module tcx_pin_sync (
    input  wire logic                  i_clk,    // Core clock
    input  wire logic                  i_rst_n,  // Sync reset, active low
    input  wire logic [`TCX_NPINS-1:0] i_pins,   // Raw pins
    output logic      [`TCX_NPINS-1:0] o_level,  // Synchronised level
    output logic      [`TCX_NPINS-1:0] o_fall    // One-cycle 1-to-0 pulse
);
    import tcx_pkg::*;

    tcx_sync_t s_r;
    tcx_sync_t s_nxt;

    always_comb
    begin
        s_nxt    = s_r;
        s_nxt.s1 = i_pins;
        s_nxt.s2 = s_r.s1;
        s_nxt.s3 = s_r.s2;
    end

    // Pins idle high so no spurious edge after reset
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n)
            s_r <= '{s1: '1, s2: '1, s3: '1};
        else
            s_r <= s_nxt;
    end

    assign o_level = s_r.s2;
    assign o_fall  = s_r.s3 & ~s_r.s2;

endmodule

// ===== tcx_pin_model.sv
// Pin-side partner: request, count and trigger sources with pull-ups
`timescale 1ns/1ns
`include "tcx_consts.svh"
module tcx_pin_model (
    input  wire logic                  i_clk,  // Core clock
    input  wire logic [`TCX_NPINS-1:0] i_pull, // Pins to drive low
    output logic      [`TCX_NPINS-1:0] o_pins  // Pin levels
);
    logic [`TCX_NPINS-1:0] lvl_r = '1;
    // Pin stays low while its pull bit is set; a released pin returns high
    always @(posedge i_clk) lvl_r <= ~i_pull;
    assign o_pins = lvl_r;
endmodule

// ===== tcx_timer_ctrl_tb.sv
// Self-checking bench of the timer and external request block
`timescale 1ns/1ns
`include "tcx_consts.svh"
module tcx_timer_ctrl_tb;
    logic       clk   = 1'b0;
    logic       rst_n = 1'b0;
    logic       wr    = 1'b0;
    logic       rd    = 1'b0;
    logic       bwr   = 1'b0;
    logic       bval  = 1'b0;
    logic [7:0] addr  = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic [7:0] baddr = 8'h00;
    logic [3:0] vec   = 4'h0;
    logic [5:0] pull  = 6'h00;
    wire  [5:0] pins;
    wire  [7:0] rdata;
    wire  [6:0] mon;
    int         n_fail      = 0;
    int         comparisons = 0;
    int         cycles      = 0;
    logic [7:0] regs [9] = '{8'h88, 8'h8A, 8'h8B, 8'h8C, 8'h8D, 8'hC8, 8'hCC, 8'hCD, 8'h90};

    tcx_pin_model tcx_pin_model_i (.i_clk(clk), .i_pull(pull), .o_pins(pins));
    tcx_timer_ctrl tcx_timer_ctrl_i (.I_CLK(clk), .I_RST_N(rst_n), .I_SFR_ADDR(addr), .I_SFR_WR(wr),
        .I_SFR_WDATA(wdata), .I_SFR_RD(rd), .O_SFR_RDATA(rdata), .I_BIT_WR(bwr), .I_BIT_ADDR(baddr),
        .I_BIT_VAL(bval), .I_VEC_TMR0(vec[0]), .I_VEC_TMR1(vec[1]), .I_VEC_EXT0(vec[2]),
        .I_VEC_EXT1(vec[3]), .I_EXT0_PIN(pins[0]), .I_EXT1_PIN(pins[1]), .I_TMR0_CNT_PIN(pins[2]),
        .I_TMR1_CNT_PIN(pins[3]), .I_TMR2_CNT_PIN(pins[4]), .I_TMR2_TRIG_PIN(pins[5]),
        .O_TMR0_OVF_FLAG(mon[0]), .O_TMR1_OVF_FLAG(mon[1]), .O_EXT0_REQ(mon[2]), .O_EXT1_REQ(mon[3]),
        .O_TMR2_IRQ(mon[4]), .O_RX_BAUD_TICK(mon[5]), .O_TX_BAUD_TICK(mon[6]));

    initial
    begin
        forever #4 clk = ~clk;
    end

    task results();
        $display("counts comparisons %0d n_fail %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            n_fail++;
            results();
        end
    end

    task chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        comparisons++;
        if (got !== exp)
        begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task wr_b(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
    endtask

    task rd_b(input logic [7:0] a, output logic [7:0] v);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        @(negedge clk);
        v = rdata;
    endtask

    task rchk(input logic [7:0] a, input logic [7:0] exp, input string nm);
        logic [7:0] v;
        rd_b(a, v);
        chk(nm, exp, v);
    endtask

    task bw(input logic [7:0] a, input logic v);
        @(posedge clk);
        baddr <= a;
        bval  <= v;
        bwr   <= 1'b1;
        @(posedge clk);
        bwr   <= 1'b0;
    endtask

    task vp(input int k);
        @(posedge clk);
        vec <= 4'h1 << k;
        @(posedge clk);
        vec <= 4'h0;
        repeat (2) @(negedge clk);
    endtask

    task pin(input int k, input logic v);
        @(posedge clk);
        pull[k] <= v;
    endtask

    // Bounded wait for one output to go high, seen at the falling edge
    task wait_bit(input int k, input string nm);
        for (int i = 0; i < 60 && mon[k] !== 1'b1; i++)
            @(negedge clk);
        chk(nm, 8'h01, {7'h0, mon[k]});
    endtask

    task t_reset();
        foreach (regs[i]) rchk(regs[i], 8'h00, "reset or unmapped read");
        $display("test reset done");
    endtask

    task t_timer01();
        logic [7:0] a;
        logic [7:0] b;
        wr_b(`TCX_A_TMR_MODE, 8'h11);
        wr_b(`TCX_A_TMR0_HIGH, 8'hFF);
        wr_b(`TCX_A_TMR0_LOW, 8'hF0);
        wr_b(`TCX_A_TMR1_HIGH, 8'hFF);
        wr_b(`TCX_A_TMR1_LOW, 8'hF0);
        rchk(`TCX_A_TMR0_LOW, 8'hF0, "lo0 idle");
        bw(8'h8C, 1'b1);
        wait_bit(0, "flag0 set");
        bw(8'h8C, 1'b0);
        rd_b(`TCX_A_TMR0_LOW, a);
        rd_b(`TCX_A_TMR0_LOW, b);
        chk("lo0 stopped", a, b);
        vp(0);
        chk("flag0 vector clear", 8'h00, {7'h0, mon[0]});
        bw(8'h8E, 1'b1);
        wait_bit(5, "rx tick from timer1");
        wait_bit(1, "flag1 set");
        bw(8'h8E, 1'b0);
        vp(1);
        chk("flag1 vector clear", 8'h00, {7'h0, mon[1]});
        $display("test timer01 done");
    endtask

    task t_ext();
        bw(8'h88, 1'b1);
        pin(0, 1'b1);
        wait_bit(2, "req0 on fall");
        pin(0, 1'b0);
        repeat (6) @(negedge clk);
        chk("req0 latched", 8'h01, {7'h0, mon[2]});
        vp(2);
        chk("req0 vector clear", 8'h00, {7'h0, mon[2]});
        pin(1, 1'b1);
        wait_bit(3, "req1 on low");
        vp(3);
        chk("req1 kept at low", 8'h01, {7'h0, mon[3]});
        pin(1, 1'b0);
        repeat (6) @(negedge clk);
        chk("req1 follows pin", 8'h00, {7'h0, mon[3]});
        $display("test ext done");
    endtask

    task t_timer2();
        wr_b(`TCX_A_TMR2_RLD_LO, 8'hF0);
        wr_b(`TCX_A_TMR2_RLD_HI, 8'hFF);
        wr_b(`TCX_A_TMR2_LOW, 8'hF8);
        wr_b(`TCX_A_TMR2_HIGH, 8'hFF);
        wr_b(`TCX_A_TMR2_CTRL, 8'h15);
        wait_bit(6, "tx tick from timer2");
        @(negedge clk);
        wait_bit(6, "tx tick after reload");
        chk("no ovf2 in baud use", 8'h00, {7'h0, mon[4]});
        wr_b(`TCX_A_TMR2_CTRL, 8'h04);
        wait_bit(4, "ovf2 flag");
        rchk(`TCX_A_TMR2_HIGH, 8'hFF, "reloaded high");
        rchk(`TCX_A_TMR2_CTRL, 8'h84, "ovf2 held");
        wr_b(`TCX_A_TMR2_CTRL, 8'h00);
        wr_b(`TCX_A_TMR2_LOW, 8'h5A);
        wr_b(`TCX_A_TMR2_HIGH, 8'hA5);
        pin(5, 1'b1);
        repeat (8) @(negedge clk);
        chk("trigger ignored", 8'h00, {7'h0, mon[4]});
        pin(5, 1'b0);
        wr_b(`TCX_A_TMR2_CTRL, 8'h09);
        pin(5, 1'b1);
        wait_bit(4, "ext flag");
        rchk(`TCX_A_TMR2_RLD_LO, 8'h5A, "capture low");
        rchk(`TCX_A_TMR2_RLD_HI, 8'hA5, "capture high");
        rchk(`TCX_A_TMR2_CTRL, 8'h49, "ext flag held");
        pin(5, 1'b0);
        $display("test timer2 done");
    endtask

    task t_sources();
        logic [7:0] a;
        wr_b(`TCX_A_TMR2_CTRL, 8'h06);
        wr_b(`TCX_A_TMR2_LOW, 8'h00);
        wr_b(`TCX_A_TMR2_HIGH, 8'h00);
        repeat (8) @(negedge clk);
        rchk(`TCX_A_TMR2_LOW, 8'h00, "lo2 waits for count pin");
        repeat (3)
        begin
            pin(4, 1'b1);
            repeat (4) @(negedge clk);
            pin(4, 1'b0);
            repeat (4) @(negedge clk);
        end
        rchk(`TCX_A_TMR2_LOW, 8'h03, "lo2 counts pin falls");
        pin(1, 1'b1);
        wr_b(`TCX_A_TMR_MODE, 8'h90);
        wr_b(`TCX_A_TMR1_LOW, 8'h00);
        wr_b(`TCX_A_TMR1_HIGH, 8'h00);
        bw(8'h8E, 1'b1);
        repeat (8) @(negedge clk);
        rchk(`TCX_A_TMR1_LOW, 8'h00, "lo1 gated off by low pin");
        pin(1, 1'b0);
        repeat (8) @(negedge clk);
        rd_b(`TCX_A_TMR1_LOW, a);
        chk("lo1 counts with high pin", 8'h01, {7'h0, a != 8'h00});
        bw(8'h8E, 1'b0);
        $display("test sources done");
    endtask

    initial
    begin
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        t_reset();
        t_timer01();
        t_ext();
        t_timer2();
        t_sources();
        results();
    end
endmodule
